// ---- verilog/ecb_cfg.svh ----
// Offsets, field positions, reset values and constants of the endpoint CSR bank
`ifndef ECB_CFG_SVH
`define ECB_CFG_SVH
`define ECB_OFF_W 24
`define ECB_OFF_LLC 24'h00004C
`define ECB_OFF_WBH 24'h000058
`define ECB_OFF_WBL 24'h00005C
`define ECB_OFF_OWN 24'h000060
`define ECB_OFF_HID 24'h000068
`define ECB_OFF_TAG 24'h00006C
`define ECB_LLC_VAL 32'h0000_0001
`define ECB_WBH_VAL 32'h0000_0000
`define ECB_WB_MSB 30
`define ECB_WB_LSB 21
`define ECB_WB_W 10
`define ECB_WB_RST 10'h000
`define ECB_NADDR_W 34
`define ECB_WIN_MSB 33
`define ECB_WIN_LSB 24
`define ECB_SID_MSB 23
`define ECB_SID_LSB 16
`define ECB_SID_RST 8'h00
`define ECB_LID_MSB 15
`define ECB_LID_RST 16'h0000
`define ECB_HID_MSB 15
`define ECB_HID_FREE 16'hFFFF
`define ECB_TAG_RST 32'h0000_0000
`define ECB_LARGE_BIT 4
`define ECB_PE_FEAT_RST 32'h0000_0010
`endif

// ---- verilog/ecb_pkg.sv ----
// Types and helper functions of the endpoint CSR bank
`include "ecb_cfg.svh"
package ecb_pkg;
    typedef enum logic [1:0] {
        ECB_IDLE = 2'b01,
        ECB_RESP = 2'b10
    } ecb_fsm_t;

    typedef enum logic [2:0] {
        ECB_SEL_NONE = 3'h0,
        ECB_SEL_LLC = 3'h1,
        ECB_SEL_WBH = 3'h2,
        ECB_SEL_WBL = 3'h3,
        ECB_SEL_OWN = 3'h4,
        ECB_SEL_HID = 3'h5,
        ECB_SEL_TAG = 3'h6
    } ecb_sel_t;

    typedef struct packed {
        ecb_fsm_t fsm;
        logic ack_m;
        logic ack_n;
        logic [31:0] rdata;
        logic [`ECB_WB_W-1:0] win_base;
        logic [7:0] sid;
        logic [15:0] lid;
        logic [15:0] hid;
        logic [31:0] tag;
    } ecb_regs_t;

    function automatic ecb_sel_t ecb_decode(input logic [`ECB_OFF_W-1:0] off);
        ecb_sel_t s;
        s = ECB_SEL_NONE;
        case (off)
            `ECB_OFF_LLC: s = ECB_SEL_LLC;
            `ECB_OFF_WBH: s = ECB_SEL_WBH;
            `ECB_OFF_WBL: s = ECB_SEL_WBL;
            `ECB_OFF_OWN: s = ECB_SEL_OWN;
            `ECB_OFF_HID: s = ECB_SEL_HID;
            `ECB_OFF_TAG: s = ECB_SEL_TAG;
            default: s = ECB_SEL_NONE;
        endcase
        return s;
    endfunction : ecb_decode

    function automatic logic [31:0] ecb_merge(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0] be);
        logic [31:0] m;
        m = old_w;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                m[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return m;
    endfunction : ecb_merge
endpackage : ecb_pkg

// ---- verilog/ecb_win_match.sv ----
// Window match and request arbitration for the endpoint CSR bank
`timescale 1ns/1ps
`default_nettype none
module ecb_win_match
    import ecb_pkg::*;
(
    input wire logic grant_en,
    input wire logic cfg_req,
    input wire logic cfg_we,
    input wire logic [`ECB_OFF_W-1:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic nrm_req,
    input wire logic nrm_we,
    input wire logic [`ECB_NADDR_W-1:0] nrm_addr,
    input wire logic [3:0] nrm_be,
    input wire logic [31:0] nrm_wdata,
    input wire logic [`ECB_WB_W-1:0] win_base,
    output logic nrm_hit,
    output logic acc_take,
    output logic acc_norm,
    output logic acc_we,
    output logic [`ECB_OFF_W-1:0] acc_off,
    output logic [3:0] acc_be,
    output logic [31:0] acc_wdata
);
    // 16 MB window: upper address bits against the stored base
    assign nrm_hit = (nrm_addr[`ECB_WIN_MSB:`ECB_WIN_LSB] == win_base);

    // Maintenance wins; a hitting normal access waits with its request held
    assign acc_norm = grant_en & ~cfg_req & nrm_req & nrm_hit;
    assign acc_take = grant_en & (cfg_req | (nrm_req & nrm_hit));
    assign acc_we = acc_norm ? nrm_we : cfg_we;
    assign acc_off = acc_norm ? nrm_addr[`ECB_WIN_LSB-1:0] : cfg_addr;
    assign acc_be = acc_norm ? nrm_be : cfg_be;
    assign acc_wdata = acc_norm ? nrm_wdata : cfg_wdata;
endmodule : ecb_win_match
`default_nettype wire

// ---- verilog/ecb_csr_bank.sv ----
// Command-and-status register bank of the packet-link endpoint logical layer
`timescale 1ns/1ps
`default_nettype none

//Behaviour
//- Every access aimed at the CSR space, maintenance or window hit, lands on one port.
//- The logical-layer control word always reads 0000_0001 and ignores writes.
//- The high window base reads all zeros and discards writes.
//- Only bits 30:21 of the low window base are writable; the rest read zero.
//- The window spans 16 MB, so the base is compared at that granularity.
//- The base matches the upper normal address bits and a hit goes to CSR space.
//- A new base at 0x5C from either path is used by all later comparisons.
//- Own identifier keeps the short id in 23:16 and the long id in 15:0.
//- The top byte of the own identifier reads zero and ignores writes.
//- After reset the host lock reads 0000_FFFF.
//- The host field takes one write while free; when held only a matching write frees it.
//- The release compare needs both low bytes written in the same access.
//- Writing FFFF into the host field leaves it free.
//- The component tag resets to zero and is fully writable from either path.
//- The long id exists only when the large-system feature bit 4 is set.
module ecb_csr_bank
    import ecb_pkg::*;
#(
    parameter logic [31:0] PE_FEAT = `ECB_PE_FEAT_RST,
    parameter logic [`ECB_WB_W-1:0] WB_RST = `ECB_WB_RST,
    parameter logic [7:0] SID_RST = `ECB_SID_RST,
    parameter logic [15:0] LID_RST = `ECB_LID_RST
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic cfg_req,
    input wire logic cfg_we,
    input wire logic [`ECB_OFF_W-1:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_ack,
    output logic [31:0] cfg_rdata,
    input wire logic nrm_req,
    input wire logic nrm_we,
    input wire logic [`ECB_NADDR_W-1:0] nrm_addr,
    input wire logic [3:0] nrm_be,
    input wire logic [31:0] nrm_wdata,
    output logic nrm_hit,
    output logic nrm_ack,
    output logic [31:0] nrm_rdata
);
    localparam logic LARGE = PE_FEAT[`ECB_LARGE_BIT];

    ecb_regs_t r;
    ecb_regs_t r_nxt;

    logic acc_take;
    logic acc_norm;
    logic acc_we;
    logic [`ECB_OFF_W-1:0] acc_off;
    logic [3:0] acc_be;
    logic [31:0] acc_wdata;
    ecb_sel_t sel;
    logic [31:0] rd_word;
    logic [31:0] merged;
    logic hid_free;

    ecb_win_match u_match (
        .grant_en(r.fsm == ECB_IDLE),
        .cfg_req(cfg_req),
        .cfg_we(cfg_we),
        .cfg_addr(cfg_addr),
        .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata),
        .nrm_req(nrm_req),
        .nrm_we(nrm_we),
        .nrm_addr(nrm_addr),
        .nrm_be(nrm_be),
        .nrm_wdata(nrm_wdata),
        .win_base(r.win_base),
        .nrm_hit(nrm_hit),
        .acc_take(acc_take),
        .acc_norm(acc_norm),
        .acc_we(acc_we),
        .acc_off(acc_off),
        .acc_be(acc_be),
        .acc_wdata(acc_wdata)
    );

    assign sel = ecb_decode(acc_off);
    assign hid_free = (r.hid == `ECB_HID_FREE);

    // Read view of the selected register; unlisted bits stay zero
    always_comb begin
        rd_word = '0;
        unique case (sel)
            ECB_SEL_NONE: rd_word = '0;
            ECB_SEL_LLC: rd_word = `ECB_LLC_VAL;
            ECB_SEL_WBH: rd_word = `ECB_WBH_VAL;
            ECB_SEL_WBL: rd_word[`ECB_WB_MSB:`ECB_WB_LSB] = r.win_base;
            ECB_SEL_OWN: begin
                rd_word[`ECB_SID_MSB:`ECB_SID_LSB] = r.sid;
                if (LARGE) begin
                    rd_word[`ECB_LID_MSB:0] = r.lid;
                end
            end
            ECB_SEL_HID: rd_word[`ECB_HID_MSB:0] = r.hid;
            ECB_SEL_TAG: rd_word = r.tag;
        endcase
    end

    // Merging into the read view keeps each byte whose enable is clear at its current value
    assign merged = ecb_merge(rd_word, acc_wdata, acc_be);

    always_comb begin
        r_nxt = r;
        r_nxt.ack_m = 1'b0;
        r_nxt.ack_n = 1'b0;
        unique case (r.fsm)
            ECB_IDLE: begin
                if (acc_take) begin
                    r_nxt.fsm = ECB_RESP;
                    r_nxt.ack_m = ~acc_norm;
                    r_nxt.ack_n = acc_norm;
                    r_nxt.rdata = acc_we ? '0 : rd_word;
                    if (acc_we) begin
                        unique case (sel)
                            ECB_SEL_WBL: begin
                                r_nxt.win_base = merged[`ECB_WB_MSB:`ECB_WB_LSB];
                            end
                            ECB_SEL_OWN: begin
                                r_nxt.sid = merged[`ECB_SID_MSB:`ECB_SID_LSB];
                                if (LARGE) begin
                                    r_nxt.lid = merged[`ECB_LID_MSB:0];
                                end
                            end
                            ECB_SEL_HID: begin
                                if (hid_free) begin
                                    // A write of FFFF claims nothing
                                    r_nxt.hid = merged[`ECB_HID_MSB:0];
                                end else if (acc_be[1:0] == 2'b11 &&
                                             acc_wdata[`ECB_HID_MSB:0] == r.hid) begin
                                    r_nxt.hid = `ECB_HID_FREE;
                                end
                            end
                            ECB_SEL_TAG: r_nxt.tag = merged;
                            ECB_SEL_NONE, ECB_SEL_LLC, ECB_SEL_WBH: begin
                                r_nxt.tag = r.tag;
                            end
                        endcase
                    end
                end
            end
            ECB_RESP: r_nxt.fsm = ECB_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            r.fsm <= ECB_IDLE;
            r.ack_m <= 1'b0;
            r.ack_n <= 1'b0;
            r.rdata <= '0;
            r.win_base <= WB_RST;
            r.sid <= SID_RST;
            r.lid <= LID_RST;
            r.hid <= `ECB_HID_FREE;
            r.tag <= `ECB_TAG_RST;
        end else begin
            r <= r_nxt;
        end
    end

    assign cfg_ack = r.ack_m;
    assign nrm_ack = r.ack_n;
    assign cfg_rdata = r.rdata;
    assign nrm_rdata = r.rdata;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    property p_llc_read;
        acc_take && !acc_we && sel == ECB_SEL_LLC
        |=> (r.ack_m || r.ack_n) && r.rdata == 32'h0000_0001;
    endproperty
    a_llc_read: assert property (p_llc_read)
        else $error("control word read wrong");

    property p_wbh_read;
        acc_take && !acc_we && sel == ECB_SEL_WBH
        |=> r.rdata == 32'h0000_0000;
    endproperty
    a_wbh_read: assert property (p_wbh_read)
        else $error("high window base not zero");

    property p_wbl_bits;
        acc_take && !acc_we && sel == ECB_SEL_WBL
        |=> r.rdata[20:0] == 21'h000000 && !r.rdata[31]
            && r.rdata[30:21] == r.win_base;
    endproperty
    a_wbl_bits: assert property (p_wbl_bits)
        else $error("low window base read bits wrong");

    property p_hit_match;
        nrm_hit |-> nrm_addr[33:24] == r.win_base;
    endproperty
    a_hit_match: assert property (p_hit_match)
        else $error("window hit without base match");

    property p_norm_route;
        acc_norm && !acc_we |-> acc_off == nrm_addr[23:0]
        ##1 r.ack_n && !r.ack_m ##1 !r.ack_n;
    endproperty
    a_norm_route: assert property (p_norm_route)
        else $error("normal hit not answered as CSR access");

    property p_base_update;
        acc_take && acc_we && sel == ECB_SEL_WBL && acc_be == 4'hF
        |=> r.win_base == $past(acc_wdata[30:21]);
    endproperty
    a_base_update: assert property (p_base_update)
        else $error("window base not updated");

    property p_own_top;
        acc_take && !acc_we && sel == ECB_SEL_OWN
        |=> r.rdata[31:24] == 8'h00 && r.rdata[23:16] == r.sid;
    endproperty
    a_own_top: assert property (p_own_top)
        else $error("own identifier top byte not zero");

    property p_hid_release;
        acc_take && acc_we && sel == ECB_SEL_HID && !hid_free
        && acc_be[1:0] == 2'b11 && acc_wdata[15:0] == r.hid
        |=> r.hid == 16'hFFFF;
    endproperty
    a_hid_release: assert property (p_hid_release)
        else $error("matching write did not free host field");

    property p_hid_hold;
        acc_take && acc_we && sel == ECB_SEL_HID && !hid_free
        && (acc_be[1:0] != 2'b11 || acc_wdata[15:0] != r.hid)
        |=> $stable(r.hid);
    endproperty
    a_hid_hold: assert property (p_hid_hold)
        else $error("held host field changed");

    property p_hid_ffff;
        acc_take && acc_we && sel == ECB_SEL_HID && hid_free
        && acc_be[1:0] == 2'b11 && acc_wdata[15:0] == 16'hFFFF
        |=> r.hid == 16'hFFFF ##1 hid_free;
    endproperty
    a_hid_ffff: assert property (p_hid_ffff)
        else $error("FFFF write locked host field");

    property p_tag_write;
        acc_take && acc_we && sel == ECB_SEL_TAG && acc_be == 4'hF
        |=> r.tag == $past(acc_wdata);
    endproperty
    a_tag_write: assert property (p_tag_write)
        else $error("component tag not written");

    property p_rsvd_read;
        acc_take && !acc_we && sel == ECB_SEL_NONE
        |=> r.rdata == 32'h0000_0000 && (r.ack_m || r.ack_n);
    endproperty
    a_rsvd_read: assert property (p_rsvd_read)
        else $error("reserved offset read not zero");

    property p_long_gate;
        !LARGE && acc_take && !acc_we && sel == ECB_SEL_OWN
        |=> r.rdata[15:0] == 16'h0000;
    endproperty
    a_long_gate: assert property (p_long_gate)
        else $error("long id visible without large system");

    property p_ack_pulse;
        r.ack_m || r.ack_n
        |=> !r.ack_m && !r.ack_n;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("answer stood longer than one cycle");

    property p_maint_first;
        cfg_req && nrm_req && nrm_hit && r.fsm == ECB_IDLE
        |-> !acc_norm ##1 r.ack_m && !r.ack_n;
    endproperty
    a_maint_first: assert property (p_maint_first)
        else $error("normal hit served before maintenance");

    property p_llc_write;
        acc_take && acc_we && sel == ECB_SEL_LLC
        |=> $stable(r.win_base) && $stable(r.tag) && $stable(r.hid) && $stable(r.sid);
    endproperty
    a_llc_write: assert property (p_llc_write)
        else $error("control word write changed state");

    property p_wbh_write;
        acc_take && acc_we && sel == ECB_SEL_WBH
        |=> $stable(r.win_base) && $stable(r.tag) && $stable(r.hid) && $stable(r.sid);
    endproperty
    a_wbh_write: assert property (p_wbh_write)
        else $error("high window base write changed state");

    property p_rsvd_write;
        acc_take && acc_we && sel == ECB_SEL_NONE
        |=> $stable(r.win_base) && $stable(r.tag) && $stable(r.hid) && $stable(r.lid);
    endproperty
    a_rsvd_write: assert property (p_rsvd_write)
        else $error("reserved offset write changed state");

    property p_wbl_keep;
        acc_take && acc_we && sel != ECB_SEL_WBL
        |=> $stable(r.win_base);
    endproperty
    a_wbl_keep: assert property (p_wbl_keep)
        else $error("window base changed by another register");

    property p_own_write;
        acc_take && acc_we && sel == ECB_SEL_OWN && acc_be[2]
        |=> r.sid == $past(acc_wdata[23:16]);
    endproperty
    a_own_write: assert property (p_own_write)
        else $error("short identifier not written");

    property p_long_write;
        acc_take && acc_we && sel == ECB_SEL_OWN && acc_be[1:0] == 2'b11
        |=> r.lid == (LARGE ? $past(acc_wdata[15:0]) : $past(r.lid));
    endproperty
    a_long_write: assert property (p_long_write)
        else $error("long identifier write wrong for feature setting");

    property p_hid_claim;
        acc_take && acc_we && sel == ECB_SEL_HID && hid_free && acc_be[1:0] == 2'b11
        |=> r.hid == $past(acc_wdata[15:0]);
    endproperty
    a_hid_claim: assert property (p_hid_claim)
        else $error("free host field did not take the write");

    property p_reset_state;
        $fell(reset) |-> r.hid == 16'hFFFF && r.tag == 32'h0000_0000;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("host field or tag wrong after reset");

    property p_tag_read;
        acc_take && !acc_we && sel == ECB_SEL_TAG
        |=> r.rdata == r.tag && r.ack_m != r.ack_n;
    endproperty
    a_tag_read: assert property (p_tag_read)
        else $error("component tag read wrong");

    c_release: cover property (
        acc_take && acc_we && sel == ECB_SEL_HID && !hid_free
        ##1 hid_free);
    c_norm_tag: cover property (
        acc_norm && acc_we && sel == ECB_SEL_TAG);
    c_norm_base: cover property (
        acc_norm && acc_we && sel == ECB_SEL_WBL
        ##1 !$stable(r.win_base));
    c_both_req: cover property (
        cfg_req && nrm_req && nrm_hit && r.fsm == ECB_IDLE);
endmodule : ecb_csr_bank
`default_nettype wire

// ---- dv/ecb_host_model.sv ----
// Remote host model issuing maintenance and normal accesses to the CSR bank
`timescale 1ns/1ps
`default_nettype none
module ecb_host_model (
    input wire logic ref_clk,
    output logic cfg_req,
    output logic cfg_we,
    output logic [23:0] cfg_addr,
    output logic [3:0] cfg_be,
    output logic [31:0] cfg_wdata,
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata,
    output logic nrm_req,
    output logic nrm_we,
    output logic [33:0] nrm_addr,
    output logic [3:0] nrm_be,
    output logic [31:0] nrm_wdata,
    input wire logic nrm_ack,
    input wire logic [31:0] nrm_rdata
);
    initial begin
        {cfg_req, cfg_we, cfg_addr, cfg_be, cfg_wdata} = '0;
        {nrm_req, nrm_we, nrm_addr, nrm_be, nrm_wdata} = '0;
    end
    // Request held until ack seen or six rising edges pass; released lines are scrambled so stale data cannot pass
    task automatic acc(input logic n, input logic we, input logic [33:0] a,
                       input logic [3:0] be, input logic [31:0] wd,
                       output logic [31:0] rd, output logic ack);
        int k;
        ack = 1'b0;
        rd = 'x;
        k = 0;
        @(negedge ref_clk);
        if (n) begin
            {nrm_req, nrm_we, nrm_addr, nrm_be, nrm_wdata} <= {1'b1, we, a, be, wd};
        end else begin
            {cfg_req, cfg_we, cfg_addr, cfg_be, cfg_wdata} <= {1'b1, we, a[23:0], be, wd};
        end
        while (!ack && k < 6) begin
            @(posedge ref_clk);
            k++;
            ack = n ? nrm_ack : cfg_ack;
        end
        if (ack) begin
            rd = n ? nrm_rdata : cfg_rdata;
        end
        @(negedge ref_clk);
        // Only the own path is released, so the other path may still be waiting
        if (n) begin
            nrm_req <= 1'b0;
            {nrm_addr, nrm_wdata, nrm_be} <= ~{nrm_addr, nrm_wdata, nrm_be};
        end else begin
            cfg_req <= 1'b0;
            {cfg_addr, cfg_wdata, cfg_be} <= ~{cfg_addr, cfg_wdata, cfg_be};
        end
    endtask : acc
endmodule : ecb_host_model
`default_nettype wire

// ---- dv/endpoint_csr_bank_bench.sv ----
// Self-checking bench of the endpoint CSR bank
`timescale 1ns/1ps
`default_nettype none
`include "ecb_cfg.svh"
module endpoint_csr_bank_bench;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic cfg_req, cfg_we, cfg_ack, nrm_req, nrm_we, nrm_hit, nrm_ack;
    logic [23:0] cfg_addr;
    logic [33:0] nrm_addr;
    logic [3:0] cfg_be, nrm_be;
    logic [31:0] cfg_wdata, cfg_rdata, nrm_wdata, nrm_rdata;
    int num_errors = 0;
    int tests_run = 0;
    logic [31:0] small_rdata;
    logic nrm_req_d = 1'b0;
    logic hit_seen = 1'b0;
    always #25 ref_clk = ~ref_clk;
    // Hit flag as it stands at the edge where each normal request is first seen
    always @(posedge ref_clk) begin
        nrm_req_d <= nrm_req;
        if (nrm_req && !nrm_req_d) begin
            hit_seen <= nrm_hit;
        end
    end
    ecb_csr_bank #(.WB_RST(10'h155), .SID_RST(8'hA5), .LID_RST(16'h1234)) uut (
        .ref_clk(ref_clk), .reset(reset), .cfg_req(cfg_req), .cfg_we(cfg_we),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
        .cfg_rdata(cfg_rdata), .nrm_req(nrm_req), .nrm_we(nrm_we), .nrm_addr(nrm_addr),
        .nrm_be(nrm_be), .nrm_wdata(nrm_wdata), .nrm_hit(nrm_hit), .nrm_ack(nrm_ack),
        .nrm_rdata(nrm_rdata));
    // Same bank without large-system support, driven by the same host in lockstep
    ecb_csr_bank #(.PE_FEAT(32'h0000_0000), .WB_RST(10'h155), .SID_RST(8'hA5),
                   .LID_RST(16'h1234)) uut_small (
        .ref_clk(ref_clk), .reset(reset), .cfg_req(cfg_req), .cfg_we(cfg_we),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(),
        .cfg_rdata(small_rdata), .nrm_req(nrm_req), .nrm_we(nrm_we), .nrm_addr(nrm_addr),
        .nrm_be(nrm_be), .nrm_wdata(nrm_wdata), .nrm_hit(), .nrm_ack(),
        .nrm_rdata());
    ecb_host_model host (
        .ref_clk(ref_clk), .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
        .nrm_req(nrm_req), .nrm_we(nrm_we), .nrm_addr(nrm_addr), .nrm_be(nrm_be),
        .nrm_wdata(nrm_wdata), .nrm_ack(nrm_ack), .nrm_rdata(nrm_rdata));
    task automatic test_done();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [33:0] m(input logic [23:0] o);
        return {10'h000, o};
    endfunction : m
    // A missing ack leaves the data unknown, so every data compare also proves the ack
    task automatic rd(input logic n, input logic [33:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic k;
        host.acc(n, 1'b0, a, 4'hF, 32'h0, d, k);
        chk(d, exp);
        if (n) begin
            chk({31'h0, hit_seen}, 32'h1);
        end
    endtask : rd
    task automatic wr(input logic n, input logic [33:0] a, input logic [3:0] be,
                      input logic [31:0] v);
        logic [31:0] d;
        logic k;
        host.acc(n, 1'b1, a, be, v, d, k);
        chk(d, 32'h0);
        if (n) begin
            chk({31'h0, hit_seen}, 32'h1);
        end
    endtask : wr
    task automatic miss(input logic [33:0] a);
        logic [31:0] d;
        logic k;
        host.acc(1'b1, 1'b0, a, 4'hF, 32'h0, d, k);
        chk({31'h0, k}, 32'h0);
        chk({31'h0, hit_seen}, 32'h0);
    endtask : miss
    // Maintenance and a window hit raised together: the maintenance write lands first
    task automatic both(input logic [31:0] v);
        logic [31:0] d0;
        logic [31:0] d1;
        logic k0;
        logic k1;
        fork
            host.acc(1'b0, 1'b1, m(`ECB_OFF_TAG), 4'hF, v, d0, k0);
            host.acc(1'b1, 1'b0, {10'h0F0, `ECB_OFF_TAG}, 4'hF, 32'h0, d1, k1);
        join
        chk(d0, 32'h0);
        chk(d1, v);
    endtask : both
    initial begin
        #100000;
        num_errors++;
        test_done();
    end
    initial begin
        repeat (10) @(negedge ref_clk);
        reset = 1'b0;
        rd(0, m(`ECB_OFF_LLC), 32'h0000_0001);
        rd(0, m(`ECB_OFF_WBH), 32'h0000_0000);
        rd(0, m(`ECB_OFF_WBL), 32'h2AA0_0000);
        rd(0, m(`ECB_OFF_OWN), 32'h00A5_1234);
        chk(small_rdata, 32'h00A5_0000);
        rd(0, m(`ECB_OFF_HID), 32'h0000_FFFF);
        rd(0, m(`ECB_OFF_TAG), 32'h0000_0000);
        wr(0, m(`ECB_OFF_LLC), 4'hF, 32'hFFFF_FFFF);
        wr(0, m(`ECB_OFF_WBH), 4'hF, 32'hFFFF_FFFF);
        wr(0, m(24'h000064), 4'hF, 32'hFFFF_FFFF);
        wr(0, m(24'h000070), 4'hF, 32'hFFFF_FFFF);
        rd(0, m(`ECB_OFF_LLC), 32'h0000_0001);
        rd(0, m(`ECB_OFF_WBH), 32'h0000_0000);
        rd(0, m(24'h000064), 32'h0000_0000);
        rd(0, m(24'h000070), 32'h0000_0000);
        wr(0, m(`ECB_OFF_WBL), 4'hF, 32'hFFFF_FFFF);
        rd(0, m(`ECB_OFF_WBL), 32'h7FE0_0000);
        wr(0, m(`ECB_OFF_WBL), 4'hF, 32'h5540_0000);
        wr(1, {10'h2AA, `ECB_OFF_TAG}, 4'hF, 32'hDEAD_BEEF);
        rd(0, m(`ECB_OFF_TAG), 32'hDEAD_BEEF);
        rd(1, {10'h2AA, `ECB_OFF_OWN}, 32'h00A5_1234);
        rd(1, {10'h2AA, 24'hFFFFFC}, 32'h0000_0000);
        miss({10'h155, `ECB_OFF_TAG});
        miss({10'h2AB, `ECB_OFF_TAG});
        wr(1, {10'h2AA, `ECB_OFF_WBL}, 4'hF, 32'h1E00_0000);
        miss({10'h2AA, `ECB_OFF_TAG});
        rd(1, {10'h0F0, `ECB_OFF_TAG}, 32'hDEAD_BEEF);
        both(32'hCAFE_F00D);
        wr(0, m(`ECB_OFF_OWN), 4'hF, 32'hFFFF_FFFF);
        rd(0, m(`ECB_OFF_OWN), 32'h00FF_FFFF);
        chk(small_rdata, 32'h00FF_0000);
        wr(0, m(`ECB_OFF_OWN), 4'h4, 32'h0033_0000);
        rd(0, m(`ECB_OFF_OWN), 32'h0033_FFFF);
        wr(0, m(`ECB_OFF_HID), 4'hF, 32'h0000_0012);
        rd(0, m(`ECB_OFF_HID), 32'h0000_0012);
        wr(0, m(`ECB_OFF_HID), 4'hF, 32'h0000_0034);
        rd(0, m(`ECB_OFF_HID), 32'h0000_0012);
        wr(0, m(`ECB_OFF_HID), 4'h1, 32'h0000_0012);
        rd(0, m(`ECB_OFF_HID), 32'h0000_0012);
        wr(0, m(`ECB_OFF_HID), 4'hF, 32'hFFFF_0012);
        rd(0, m(`ECB_OFF_HID), 32'h0000_FFFF);
        wr(0, m(`ECB_OFF_HID), 4'hF, 32'h0000_FFFF);
        wr(0, m(`ECB_OFF_HID), 4'hF, 32'h0000_0056);
        rd(0, m(`ECB_OFF_HID), 32'h0000_0056);
        wr(0, m(`ECB_OFF_TAG), 4'hA, 32'h1122_3344);
        rd(0, m(`ECB_OFF_TAG), 32'h11FE_330D);
        reset = 1'b1;
        repeat (3) @(negedge ref_clk);
        reset = 1'b0;
        rd(0, m(`ECB_OFF_TAG), 32'h0000_0000);
        rd(0, m(`ECB_OFF_HID), 32'h0000_FFFF);
        rd(1, {10'h155, `ECB_OFF_WBL}, 32'h2AA0_0000);
        test_done();
    end
endmodule : endpoint_csr_bank_bench
`default_nettype wire
